// File: rtl/csc_system_control.sv
/*
  Codec system control register bank: interrupt event and mask, sample
  rate selection, gain ramp timing, sequencer sync, soft reset, ADC mode
  and gain swap settings.
  Assumes a byte register port from the serial control interface on the
  same clock, and asynchronous level-detect and word clock inputs.
*/
module csc_system_control
  import csc_pkg::*;
#(
  parameter int RAMP_CYCLES = RAMP_NOMINAL_CYCLES,
  parameter int FRAME_CYCLES = SEQ_FRAME_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire csc_req_s cif_req,
  output logic [7:0] cif_rdata,
  input wire logic level_over_threshold,
  input wire logic dai_word_clk,
  output logic host_interrupt_n,
  output logic [3:0] record_sample_rate,
  output logic [3:0] playback_sample_rate,
  output logic [3:0] dai_sample_rate,
  output logic repeat_record_samples,
  output logic repeat_playback_samples,
  output logic gain_ramp_step,
  output logic [SEQ_CNT_W-1:0] sequencer_count,
  output logic sequencer_frame_start,
  output logic adc_one_aaf_on,
  output logic adc_two_aaf_on,
  output logic adc_low_power_on,
  output logic adc_level_detect_on,
  output logic [1:0] gain_swap_enable,
  output logic [7:0] gain_swap_trigger_db,
  output logic [7:0] gain_swap_att_db,
  output logic gain_swap_timeout_on,
  output logic gain_swap_clip_on
);

  // Control registers.
  logic [3:0] gs_trigger;
  logic [2:0] gs_att;
  logic auto_exit;
  logic level_detect_flag;
  logic event_mask;
  logic [1:0] ramp_rate;
  logic sequencer_auto_resync;
  logic sequencer_free_running;

  // Synchronised pins and edge history.
  logic [1:0] pins_sync;
  logic level_prev;
  logic wclk_prev;
  csc_seq_e seq_state;
  logic [RAMP_CNT_W-1:0] ramp_cnt;

  csc_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in({dai_word_clk, level_over_threshold}),
    .sync_out(pins_sync)
  );

  wire level_rise = pins_sync[0] & ~level_prev;
  wire wclk_rise = pins_sync[1] & ~wclk_prev;

  // Address decode.
  wire wr = cif_req.wr;
  wire [7:0] wd = cif_req.wdata;
  wire [7:0] ad = cif_req.addr;
  wire wr_gs_en = wr && ad == OFS_GS_ENABLE;
  wire wr_gs_trig = wr && ad == OFS_GS_TRIGGER;
  wire wr_gs_att = wr && ad == OFS_GS_ATT_LIMIT;
  wire wr_gs_to = wr && ad == OFS_GS_TIMEOUT;
  wire wr_gs_clip = wr && ad == OFS_GS_CLIP;
  wire wr_rate = wr && ad == OFS_SAMPLE_RATE;
  wire wr_ramp = wr && ad == OFS_RAMP_CTRL;
  wire wr_seq = wr && ad == OFS_SEQ_SYNC;
  wire wr_event = wr && ad == OFS_EVENT;
  wire wr_mask = wr && ad == OFS_EVENT_MASK;
  wire wr_adc1 = wr && ad == OFS_ADC_ONE;
  wire wr_adc2 = wr && ad == OFS_ADC_TWO;
  wire wr_mode = wr && ad == OFS_ADC_MODE;
  // Abrupt: nothing is faded, so the host must mute paths first.
  wire soft_reset = wr && ad == OFS_SOFT_RESET && wd == SOFT_RESET_KEY;
  wire any_rst = sys_rst | soft_reset;

  // Level event only counts while detection mode is on.
  wire level_event = level_rise & adc_level_detect_on;
  wire flag_clear = wr_event & wd[FLAG_BIT];
  // A new event wins over a host clear in the same cycle.
  wire next_flag = level_event | (level_detect_flag & ~flag_clear);
  // Auto-exit drops the mode bit; the hardware clear beats a host write.
  wire exit_now = level_event & auto_exit;
  wire next_lvldet = exit_now ? 1'b0 :
                     (wr_mode ? wd[LVLDET_BIT] : adc_level_detect_on);
  wire next_irq_n = ~(next_flag & ~event_mask);

  // Read mux; unmapped and reserved bits read zero.
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    unique case (ad)
      OFS_GS_ENABLE: next_rdata = {6'h00, gain_swap_enable};
      OFS_GS_TRIGGER: next_rdata = {4'h0, gs_trigger};
      OFS_GS_ATT_LIMIT: next_rdata = {5'h00, gs_att};
      OFS_GS_TIMEOUT: next_rdata[TIMEOUT_BIT] = gain_swap_timeout_on;
      OFS_GS_CLIP: next_rdata[CLIP_BIT] = gain_swap_clip_on;
      OFS_SAMPLE_RATE: next_rdata = {playback_sample_rate, record_sample_rate};
      OFS_RAMP_CTRL: next_rdata = {6'h00, ramp_rate};
      OFS_SEQ_SYNC: begin
        next_rdata[RESYNC_BIT] = sequencer_auto_resync;
        next_rdata[FREERUN_BIT] = sequencer_free_running;
      end
      OFS_EVENT: next_rdata[FLAG_BIT] = level_detect_flag;
      OFS_EVENT_MASK: next_rdata[FLAG_BIT] = event_mask;
      OFS_ADC_ONE: next_rdata[AAF_BIT] = adc_one_aaf_on;
      OFS_ADC_TWO: next_rdata[AAF_BIT] = adc_two_aaf_on;
      OFS_ADC_MODE: begin
        next_rdata[AUTO_EXIT_BIT] = auto_exit;
        next_rdata[LVLDET_BIT] = adc_level_detect_on;
        next_rdata[LP_BIT] = adc_low_power_on;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cif_rdata <= 8'h00;
    end else if (cif_req.rd) begin
      cif_rdata <= next_rdata;
    end
  end

  // Register bank; soft reset restores every default.
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      gain_swap_enable <= RST_GS_ENABLE;
      gs_trigger <= RST_GS_TRIGGER;
      gs_att <= RST_GS_ATT;
      gain_swap_timeout_on <= RST_OFF;
      gain_swap_clip_on <= RST_OFF;
      record_sample_rate <= RST_RATE;
      playback_sample_rate <= RST_RATE;
      ramp_rate <= RST_RAMP;
      sequencer_auto_resync <= RST_OFF;
      sequencer_free_running <= RST_OFF;
      event_mask <= RST_MASK;
      adc_one_aaf_on <= RST_AAF;
      adc_two_aaf_on <= RST_AAF;
      auto_exit <= RST_OFF;
      adc_low_power_on <= RST_OFF;
    end else begin
      if (wr_gs_en) gain_swap_enable <= wd[1:0];
      if (wr_gs_trig) gs_trigger <= wd[3:0];
      if (wr_gs_att) gs_att <= wd[2:0];
      if (wr_gs_to) gain_swap_timeout_on <= wd[TIMEOUT_BIT];
      if (wr_gs_clip) gain_swap_clip_on <= wd[CLIP_BIT];
      if (wr_rate) begin
        record_sample_rate <= wd[3:0];
        playback_sample_rate <= wd[7:4];
      end
      if (wr_ramp) ramp_rate <= wd[1:0];
      if (wr_seq) begin
        sequencer_auto_resync <= wd[RESYNC_BIT];
        sequencer_free_running <= wd[FREERUN_BIT];
      end
      if (wr_mask) event_mask <= wd[FLAG_BIT];
      if (wr_adc1) adc_one_aaf_on <= wd[AAF_BIT];
      if (wr_adc2) adc_two_aaf_on <= wd[AAF_BIT];
      if (wr_mode) begin
        auto_exit <= wd[AUTO_EXIT_BIT];
        adc_low_power_on <= wd[LP_BIT];
      end
    end
  end

  // Event path and mode bit that hardware can also clear.
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      level_detect_flag <= RST_OFF;
      adc_level_detect_on <= RST_OFF;
      host_interrupt_n <= 1'b1;
    end else begin
      level_detect_flag <= next_flag;
      adc_level_detect_on <= next_lvldet;
      host_interrupt_n <= next_irq_n;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      level_prev <= 1'b0;
      wclk_prev <= 1'b0;
    end else begin
      level_prev <= pins_sync[0];
      wclk_prev <= pins_sync[1];
    end
  end

  // Decoded gain swap levels in dB; a reserved limit clamps to 36 dB.
  wire [2:0] att_code = (gs_att == ATT_RESERVED) ? 3'h6 : gs_att;
  wire [7:0] next_trig_db = 8'({4'h0, gs_trigger} * DB_STEP);
  wire [7:0] next_att_db = 8'({5'h00, att_code} * DB_STEP);

  // Rate codes rise with sample rate; the slower path is repeated.
  wire play_faster = playback_sample_rate > record_sample_rate;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gain_swap_trigger_db <= 8'h00;
      gain_swap_att_db <= 8'h00;
      dai_sample_rate <= RST_RATE;
      repeat_record_samples <= 1'b0;
      repeat_playback_samples <= 1'b0;
    end else begin
      gain_swap_trigger_db <= next_trig_db;
      gain_swap_att_db <= next_att_db;
      dai_sample_rate <= play_faster ? playback_sample_rate
                                     : record_sample_rate;
      repeat_record_samples <= play_faster;
      repeat_playback_samples <= record_sample_rate > playback_sample_rate;
    end
  end

  // Gain ramp step period per dB from the shared rate field.
  logic [RAMP_CNT_W-1:0] ramp_period;
  always_comb begin
    ramp_period = RAMP_CNT_W'(RAMP_CYCLES);
    unique case (ramp_rate)
      RAMP_FAST: ramp_period = RAMP_CNT_W'(RAMP_CYCLES / 8);
      RAMP_NOMINAL: ramp_period = RAMP_CNT_W'(RAMP_CYCLES);
      RAMP_DIV8: ramp_period = RAMP_CNT_W'(RAMP_CYCLES * 8);
      RAMP_DIV16: ramp_period = RAMP_CNT_W'(RAMP_CYCLES * 16);
    endcase
  end

  wire ramp_done = ramp_cnt >= ramp_period - RAMP_CNT_W'(1);

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      ramp_cnt <= '0;
      gain_ramp_step <= 1'b0;
    end else begin
      ramp_cnt <= ramp_done ? '0 : ramp_cnt + RAMP_CNT_W'(1);
      gain_ramp_step <= ramp_done;
    end
  end

  // Sequencer: waits for the first word clock edge unless free running,
  // then wraps on its own frame count. Auto-resync realigns on each edge unless free running.
  wire frame_end = sequencer_count == SEQ_CNT_W'(FRAME_CYCLES - 1);
  wire resync = wclk_rise & sequencer_auto_resync & ~sequencer_free_running;
  csc_seq_e next_seq_state;
  always_comb begin
    next_seq_state = seq_state;
    unique case (seq_state)
      SEQ_WAIT: if (wclk_rise || sequencer_free_running) begin
        next_seq_state = SEQ_RUN;
      end
      SEQ_RUN: next_seq_state = SEQ_RUN;
    endcase
  end

  wire seq_start = (seq_state == SEQ_WAIT && next_seq_state == SEQ_RUN)
                   || (seq_state == SEQ_RUN && (resync || frame_end));

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      seq_state <= SEQ_WAIT;
      sequencer_count <= '0;
      sequencer_frame_start <= 1'b0;
    end else begin
      seq_state <= next_seq_state;
      sequencer_frame_start <= seq_start;
      if (seq_start) begin
        sequencer_count <= '0;
      end else if (seq_state == SEQ_RUN) begin
        sequencer_count <= sequencer_count + SEQ_CNT_W'(1);
      end
    end
  end

endmodule : csc_system_control

// File: rtl/csc_pkg.sv
/*
  Package for the codec system control block: register offsets, field
  positions, reset values, timing counts and shared types.
  Assumes a 200 MHz core clock and an 8-bit register port behind the
  serial control interface.
*/
package csc_pkg;

  // Register offsets on the control interface.
  localparam logic [7:0] OFS_GS_ENABLE = 8'h3c;
  localparam logic [7:0] OFS_GS_TRIGGER = 8'h3d;
  localparam logic [7:0] OFS_GS_ATT_LIMIT = 8'h3e;
  localparam logic [7:0] OFS_GS_TIMEOUT = 8'h3f;
  localparam logic [7:0] OFS_GS_CLIP = 8'h40;
  localparam logic [7:0] OFS_SAMPLE_RATE = 8'h60;
  localparam logic [7:0] OFS_RAMP_CTRL = 8'h61;
  localparam logic [7:0] OFS_SEQ_SYNC = 8'h62;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h63;
  localparam logic [7:0] OFS_EVENT = 8'h64;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h65;
  localparam logic [7:0] OFS_ADC_ONE = 8'hc0;
  localparam logic [7:0] OFS_ADC_TWO = 8'hc1;
  localparam logic [7:0] OFS_ADC_MODE = 8'hc2;

  // Field positions.
  localparam int AAF_BIT = 2;
  localparam int LP_BIT = 0;
  localparam int LVLDET_BIT = 1;
  localparam int AUTO_EXIT_BIT = 2;
  localparam int RESYNC_BIT = 0;
  localparam int FREERUN_BIT = 1;
  localparam int TIMEOUT_BIT = 0;
  localparam int CLIP_BIT = 7;
  localparam int FLAG_BIT = 0;

  // Reset values.
  localparam logic [1:0] RST_GS_ENABLE = 2'h0;
  localparam logic [3:0] RST_GS_TRIGGER = 4'h9;
  localparam logic [2:0] RST_GS_ATT = 3'h0;
  localparam logic RST_AAF = 1'b1;
  localparam logic RST_OFF = 1'b0;
  localparam logic RST_MASK = 1'b1;
  localparam logic [3:0] RST_RATE = 4'h0;
  localparam logic [1:0] RST_RAMP = 2'h1;
  localparam logic [7:0] SOFT_RESET_KEY = 8'h80;
  localparam logic [2:0] ATT_RESERVED = 3'h7;
  localparam logic [7:0] DB_STEP = 8'h06;

  // Ramp rate codes.
  localparam logic [1:0] RAMP_FAST = 2'h0;
  localparam logic [1:0] RAMP_NOMINAL = 2'h1;
  localparam logic [1:0] RAMP_DIV8 = 2'h2;
  localparam logic [1:0] RAMP_DIV16 = 2'h3;

  // Timing: nominal ramp is 0.88 ms per dB.
  localparam int CLK_PERIOD_PS = 5000;
  localparam longint RAMP_NOMINAL_PS = 64'd880_000_000;
  localparam int RAMP_NOMINAL_CYCLES = int'(RAMP_NOMINAL_PS / CLK_PERIOD_PS);
  // One 48 kHz frame, the wrap count whenever the sequencer runs.
  localparam longint SEQ_FRAME_PS = 64'd20_833_333;
  localparam int SEQ_FRAME_CYCLES = int'(SEQ_FRAME_PS / CLK_PERIOD_PS);
  localparam int RAMP_CNT_W = 24;
  localparam int SEQ_CNT_W = 16;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csc_req_s;

  typedef enum logic {
    SEQ_WAIT = 1'b0,
    SEQ_RUN = 1'b1
  } csc_seq_e;

endpackage : csc_pkg

// File: rtl/csc_sync2.sv
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a slow level or a clock far below core_clk.
*/
module csc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : csc_sync2

// File: verif/csc_props.sv
/*
  Port checker for the codec system control block.
  Assumes it is bound to csc_system_control and sees only its ports.
*/
module csc_props
  import csc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire csc_req_s cif_req,
  input wire logic host_interrupt_n,
  input wire logic level_over_threshold,
  input wire logic [3:0] record_sample_rate,
  input wire logic [3:0] playback_sample_rate,
  input wire logic [3:0] dai_sample_rate,
  input wire logic adc_one_aaf_on,
  input wire logic [7:0] gain_swap_trigger_db,
  input wire logic [7:0] gain_swap_att_db
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr(logic [7:0] a);
    cif_req.wr && cif_req.addr == a;
  endsequence
  sequence s_key;
    s_wr(OFS_SOFT_RESET) ##0 cif_req.wdata == SOFT_RESET_KEY;
  endsequence
  // The stored mask reaches the interrupt flop one cycle after the write.
  property p_mask_off;
    s_wr(OFS_EVENT_MASK) ##0 cif_req.wdata[FLAG_BIT] |=> ##1 host_interrupt_n;
  endproperty
  property p_soft_rst;
    s_key |=> adc_one_aaf_on && host_interrupt_n;
  endproperty
  property p_aaf;
    s_wr(OFS_ADC_ONE) |=> adc_one_aaf_on == $past(cif_req.wdata[AAF_BIT]);
  endproperty
  property p_trig;
    s_wr(OFS_GS_TRIGGER) |=> ##1
      gain_swap_trigger_db == 8'($past(cif_req.wdata[3:0], 2)) * DB_STEP;
  endproperty
  property p_att;
    s_wr(OFS_GS_ATT_LIMIT) |=> ##1 gain_swap_att_db ==
      (($past(cif_req.wdata[2:0], 2) == ATT_RESERVED) ? 8'h24 :
      8'($past(cif_req.wdata[2:0], 2)) * DB_STEP);
  endproperty
  property p_dai;
    1'b1 |=> dai_sample_rate ==
      (($past(record_sample_rate) > $past(playback_sample_rate)) ?
      $past(record_sample_rate) : $past(playback_sample_rate));
  endproperty
  // A fall with no write two cycles before it can only come from a level
  // event, and the pin was already high three samples before the fall.
  property p_cause;
    $fell(host_interrupt_n) && !$past(cif_req.wr, 2) |->
      $past(level_over_threshold, 3);
  endproperty
  // A mask write releases the line one cycle late, so it is excluded too.
  property p_hold;
    !host_interrupt_n && !cif_req.wr && !$past(cif_req.wr) |=>
      !host_interrupt_n;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("irq not masked");
  a_soft_rst: assert property (p_soft_rst)
    else $error("soft reset");
  a_aaf: assert property (p_aaf)
    else $error("aaf bit wrong");
  a_trig: assert property (p_trig)
    else $error("trigger dB wrong");
  a_att: assert property (p_att)
    else $error("attenuation dB wrong");
  a_dai: assert property (p_dai)
    else $error("port rate wrong");
  a_cause: assert property (p_cause)
    else $error("irq without event");
  a_hold: assert property (p_hold)
    else $error("irq dropped");
endmodule : csc_props

bind csc_system_control csc_props u_props (
  .core_clk, .sys_rst, .cif_req, .host_interrupt_n, .level_over_threshold,
  .record_sample_rate, .playback_sample_rate, .dai_sample_rate,
  .adc_one_aaf_on, .gain_swap_trigger_db, .gain_swap_att_db
);

// File: verif/csc_host_model.sv
/*
  Host model on the register port: single byte writes and reads.
  Assumes the one-cycle strobes and next-cycle read data of the block.
*/
module csc_host_model
  import csc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] cif_rdata,
  output csc_req_s cif_req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cif_req = '0;
  // Idle address and data carry the inverse of the last request, so a
  // block that samples them outside a strobe sees changing values.
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cif_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge core_clk);
    cif_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : put
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(1'b0, a, 8'h00);
    d = cif_rdata;
  endtask : rd
endmodule : csc_host_model

// File: verif/codec_system_control_test.sv
/*
  Self-checking bench for the codec system control block.
  Assumes short ramp and frame counts given as parameters.
*/
module codec_system_control_test
  import csc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RAMP_T = 16;
  localparam int FRAME_T = 20;
  // Pin change to pulse: two synchroniser flops, then the registered output.
  localparam int SYNC_LAT = 3;
  localparam logic [7:0] RA [12] = '{OFS_GS_ENABLE, OFS_GS_TRIGGER,
    OFS_GS_ATT_LIMIT, OFS_GS_TIMEOUT, OFS_GS_CLIP, OFS_ADC_ONE, OFS_ADC_TWO,
    OFS_ADC_MODE, OFS_EVENT_MASK, OFS_RAMP_CTRL, OFS_SOFT_RESET, 8'haa};
  localparam logic [7:0] RD [12] = '{8'h00, 8'h09, 8'h00, 8'h00, 8'h00,
    8'h04, 8'h04, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] RM [12] = '{8'h03, 8'h0f, 8'h07, 8'h01, 8'h80,
    8'h04, 8'h04, 8'h07, 8'h01, 8'h03, 8'h00, 8'h00};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic level_over_threshold = 1'b0;
  logic dai_word_clk = 1'b0;
  csc_req_s cif_req;
  logic [7:0] cif_rdata, gain_swap_trigger_db, gain_swap_att_db;
  logic [3:0] record_sample_rate, playback_sample_rate, dai_sample_rate;
  logic [1:0] gain_swap_enable;
  logic [SEQ_CNT_W-1:0] sequencer_count;
  logic host_interrupt_n, repeat_record_samples, repeat_playback_samples;
  logic gain_ramp_step, sequencer_frame_start, adc_one_aaf_on;
  logic adc_two_aaf_on, adc_low_power_on, adc_level_detect_on;
  logic gain_swap_timeout_on, gain_swap_clip_on;
  wire [7:0] port_fields = {gain_swap_enable, adc_one_aaf_on, adc_two_aaf_on,
    adc_low_power_on, adc_level_detect_on, gain_swap_timeout_on,
    gain_swap_clip_on};
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #2.5 core_clk = ~core_clk;
  csc_host_model host (.core_clk, .cif_rdata, .cif_req);
  csc_system_control #(.RAMP_CYCLES(RAMP_T), .FRAME_CYCLES(FRAME_T)) dut (
    .core_clk, .sys_rst, .cif_req, .cif_rdata, .level_over_threshold,
    .dai_word_clk, .host_interrupt_n, .record_sample_rate,
    .playback_sample_rate, .dai_sample_rate, .repeat_record_samples,
    .repeat_playback_samples, .gain_ramp_step, .sequencer_count,
    .sequencer_frame_start, .adc_one_aaf_on, .adc_two_aaf_on,
    .adc_low_power_on, .adc_level_detect_on, .gain_swap_enable,
    .gain_swap_trigger_db, .gain_swap_att_db, .gain_swap_timeout_on,
    .gain_swap_clip_on);
  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask : rc
  // Counts cycles up to the next pulse, so two calls give one full period.
  task automatic gap(ref logic s, output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (!s && n < 600);
  endtask : gap
  task automatic t_regs();
    for (int i = 0; i < 12; i++) rc(RA[i], RD[i]);
    for (int i = 0; i < 12; i++) host.wr(RA[i], 8'hff);
    for (int i = 0; i < 12; i++) rc(RA[i], RM[i]);
    chk("fields", 16'h00ff, port_fields);
    for (int c = 0; c < 16; c++) host.wr(OFS_GS_TRIGGER, 8'(c));
    for (int c = 0; c < 8; c++) host.wr(OFS_GS_ATT_LIMIT, 8'(c));
    @(negedge core_clk);
    chk("att dB", 16'h0024, gain_swap_att_db);
    chk("trig dB", 16'h005a, gain_swap_trigger_db);
    host.wr(OFS_ADC_MODE, 8'h00);
    host.wr(OFS_SOFT_RESET, SOFT_RESET_KEY);
    for (int i = 0; i < 12; i++) rc(RA[i], RD[i]);
    chk("fields rst", 16'h0030, port_fields);
  endtask : t_regs
  task automatic t_rates();
    logic [7:0] v [2] = '{8'h42, 8'h24};
    for (int i = 0; i < 2; i++) begin
      host.wr(OFS_SAMPLE_RATE, v[i]);
      repeat (2) @(negedge core_clk);
      chk("dai rate", 16'h0004, dai_sample_rate);
      chk("rep rec", v[i][3:0] < v[i][7:4],
          repeat_record_samples);
      chk("rep play", v[i][7:4] < v[i][3:0],
          repeat_playback_samples);
    end
  endtask : t_rates
  task automatic t_ramp();
    int n;
    int e [4] = '{RAMP_T / 8, RAMP_T, RAMP_T * 8, RAMP_T * 16};
    for (int c = 0; c < 4; c++) begin
      host.wr(OFS_RAMP_CTRL, 8'(c));
      gap(gain_ramp_step, n);
      gap(gain_ramp_step, n);
      chk("ramp gap", 16'(e[c]), 16'(n));
    end
  endtask : t_ramp
  task automatic t_event(input logic [7:0] mode, input logic [7:0] mask);
    host.wr(OFS_EVENT_MASK, mask);
    host.wr(OFS_ADC_MODE, mode);
    level_over_threshold = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("irq_n", mask[0], host_interrupt_n);
    chk("mode", !mode[AUTO_EXIT_BIT], adc_level_detect_on);
    rc(OFS_EVENT, 8'h01);
    level_over_threshold = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("irq held", mask[0], host_interrupt_n);
    // The mask acts one cycle after its write, hence the extra edge.
    host.wr(OFS_EVENT_MASK, 8'h01);
    @(negedge core_clk);
    chk("irq masked", 1'b1, host_interrupt_n);
    host.wr(OFS_EVENT_MASK, mask);
    @(negedge core_clk);
    chk("irq unmasked", mask[0], host_interrupt_n);
    host.wr(OFS_EVENT, 8'h01);
    chk("irq clr", 1'b1, host_interrupt_n);
    rc(OFS_EVENT, 8'h00);
  endtask : t_event
  task automatic t_seq();
    int n;
    repeat (30) @(negedge core_clk);
    chk("seq idle", 16'h0000, sequencer_count);
    host.wr(OFS_SEQ_SYNC, 8'h01);
    dai_word_clk = 1'b1;
    gap(sequencer_frame_start, n);
    chk("sync start", 16'(SYNC_LAT), 16'(n));
    // A second edge well inside the frame must restart it at once.
    dai_word_clk = 1'b0;
    repeat (5) @(negedge core_clk);
    dai_word_clk = 1'b1;
    gap(sequencer_frame_start, n);
    chk("resync", 16'(SYNC_LAT), 16'(n));
    chk("resync cnt", 16'h0000, sequencer_count);
    dai_word_clk = 1'b0;
    // Back to waiting, so only free running can start the sequencer.
    host.wr(OFS_SOFT_RESET, SOFT_RESET_KEY);
    host.wr(OFS_SEQ_SYNC, 8'h02);
    gap(sequencer_frame_start, n);
    gap(sequencer_frame_start, n);
    chk("free run", 16'(FRAME_T), 16'(n));
  endtask : t_seq
  initial begin
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    t_regs();
    t_rates();
    t_ramp();
    t_event(8'h02, 8'h00);
    t_event(8'h06, 8'h00);
    t_event(8'h02, 8'h01);
    t_seq();
    end_of_test();
  end
endmodule : codec_system_control_test
